/* hw/bts_pkg.sv */
// constants for the branch store control block: register map, field positions,
// reset values, management area layout and the controller state codes.
// assumes a 32-bit apb register bus and word-sized branch records.
package bts_pkg;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  STATUS_OFS     = 8'h04;
    localparam logic [7:0]  LVT_OFS        = 8'h08;
    localparam logic [7:0]  AREA_PTR_OFS   = 8'h0C;
    localparam logic [7:0]  BUF_BASE_OFS   = 8'h10;
    localparam logic [7:0]  INDEX_OFS      = 8'h14;
    localparam logic [7:0]  ABS_MAX_OFS    = 8'h18;
    localparam logic [7:0]  THRESH_OFS     = 8'h1C;
    // control register bits
    localparam int          ON_BIT         = 0;
    localparam int          SEL_BIT        = 1;
    localparam int          IRQEN_BIT      = 2;
    localparam int          SKIPK_BIT      = 3;
    localparam int          SKIPU_BIT      = 4;
    localparam int          CTRL_W         = 5;
    // status bits, sticky, write one to clear
    localparam int          ST_TRACE       = 0;
    localparam int          ST_PREC        = 1;
    localparam int          ST_CNTOVF      = 2;
    localparam int          ST_W           = 3;
    // local vector entry mask bit
    localparam int          MASK_BIT       = 0;
    // privilege filter present in this build
    localparam logic        PRIV_FILTER    = 1'b1;
    localparam logic [1:0]  PRIV_KERNEL    = 2'h0;
    // management area word offsets from the area pointer
    localparam logic [31:0] AREA_BASE_OFS  = 32'h0;
    localparam logic [31:0] AREA_IDX_OFS   = 32'h4;
    localparam logic [31:0] AREA_MAX_OFS   = 32'h8;
    localparam logic [31:0] AREA_THR_OFS   = 32'hC;
    localparam logic [1:0]  FETCH_LAST     = 2'h3;
    // one record is one word
    localparam logic [31:0] RECORD_SIZE    = 32'h4;
    localparam logic [31:0] WORD_ZERO      = 32'h0;
    // controller states
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_FETCH = 2'b01,
        S_WRITE = 2'b10
    } bts_state_t;
endpackage

/* hw/bts_store_ctrl.sv */
// branch record router: sends records to the bus monitor port or stores them
// in a memory trace buffer described by a management area, with one shared irq.
// assumes records, memory answers and overflow events come from logic on clock.
//////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: the register offsets and the APB register port.

module bts_store_ctrl (
    input  logic        clock,
    input  logic        rstn,
    input  logic        clockEn,
    // apb slave
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [7:0]  paddr,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    // branch records from the core
    input  logic        recValid,
    input  logic [31:0] recData,
    input  logic [1:0]  recPriv,
    output logic        recReady,
    // branch message to the system bus
    output logic        busMsgValid,
    output logic [31:0] busMsgData,
    // memory port for the management area and the trace buffer
    output logic        memReq,
    output logic        memWrite,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input  logic        memAck,
    input  logic [31:0] memRdata,
    // other interrupt sources
    input  logic [31:0] precIndex,
    input  logic [31:0] precThresh,
    input  logic        counterOverflow,
    output logic        perfIrq
);
    logic [bts_pkg::CTRL_W-1:0] ctrl_reg;
    logic [bts_pkg::ST_W-1:0]   status_reg;
    logic [bts_pkg::ST_W-1:0]   statusSet;
    logic [31:0]                areaPtr_reg, base_reg, index_reg, absMax_reg, thresh_reg, index_next;
    logic [31:0]                prdata_reg, busMsgData_reg, memAddr_reg, memWdata_reg;
    logic                       lvtMask_reg, fieldsValid_reg, pready_reg, pslverr_reg, recReady_reg;
    logic                       busMsgValid_reg, memReq_reg, memWrite_reg, perfIrq_reg;
    logic [1:0]                 fetchCnt_reg;
    bts_pkg::bts_state_t        state_reg;
    bts_pkg::bts_state_t        state_next;
    logic                       apbWr, mapped, msgOn, storeMode, privOk, bothSkip, bufFull;
    logic                       acceptRec, sendBus, sendStore, storeDone, fetchDone, wrIndex;

    //////////////////////////////////////////////////////////////////////////
    // apb decode: no wait state, answer registered

    always_comb begin
        mapped = (paddr[1:0] == 2'b00) && (paddr <= bts_pkg::THRESH_OFS);
        apbWr  = clockEn && psel && penable && pready_reg && pwrite && mapped;
        wrIndex = apbWr && (paddr == bts_pkg::INDEX_OFS);
    end

    // setup cycle loads read data, access cycle completes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= bts_pkg::WORD_ZERO;
        end else if (clockEn) begin
            if (psel && !penable && !pready_reg) begin
                pready_reg  <= 1'b1;
                pslverr_reg <= !mapped;
                unique case (paddr)
                    bts_pkg::CTRL_OFS:     prdata_reg <= 32'(ctrl_reg);
                    bts_pkg::STATUS_OFS:   prdata_reg <= 32'(status_reg);
                    bts_pkg::LVT_OFS:      prdata_reg <= 32'(lvtMask_reg);
                    bts_pkg::AREA_PTR_OFS: prdata_reg <= areaPtr_reg;
                    bts_pkg::BUF_BASE_OFS: prdata_reg <= base_reg;
                    bts_pkg::INDEX_OFS:    prdata_reg <= index_reg;
                    bts_pkg::ABS_MAX_OFS:  prdata_reg <= absMax_reg;
                    bts_pkg::THRESH_OFS:   prdata_reg <= thresh_reg;
                    default:               prdata_reg <= bts_pkg::WORD_ZERO;
                endcase
            end else begin
                pready_reg  <= 1'b0;
                pslverr_reg <= 1'b0;
            end
        end
    end

    // control flags written by software
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg    <= '0;
            areaPtr_reg <= bts_pkg::WORD_ZERO;
        end else if (apbWr) begin
            if (paddr == bts_pkg::CTRL_OFS)
                ctrl_reg <= pwdata[bts_pkg::CTRL_W-1:0];
            if (paddr == bts_pkg::AREA_PTR_OFS)
                areaPtr_reg <= pwdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // record routing

    always_comb begin
        msgOn     = ctrl_reg[bts_pkg::ON_BIT];
        storeMode = msgOn && ctrl_reg[bts_pkg::SEL_BIT];
        bothSkip  = bts_pkg::PRIV_FILTER && ctrl_reg[bts_pkg::SKIPK_BIT] && ctrl_reg[bts_pkg::SKIPU_BIT];
        privOk    = !bts_pkg::PRIV_FILTER
                    || !((ctrl_reg[bts_pkg::SKIPK_BIT] && recPriv == bts_pkg::PRIV_KERNEL)
                    || (ctrl_reg[bts_pkg::SKIPU_BIT] && recPriv != bts_pkg::PRIV_KERNEL));
        // full non-circular buffer drops records, stays enabled
        bufFull   = ctrl_reg[bts_pkg::IRQEN_BIT] && (index_reg >= absMax_reg);
        acceptRec = clockEn && recValid && recReady_reg;
        // nothing leaves while messages are off
        // both skip bits: message generated, not stored
        sendBus   = acceptRec && msgOn && (!ctrl_reg[bts_pkg::SEL_BIT] || bothSkip);
        // store path excludes the bus path
        sendStore = acceptRec && storeMode && !bothSkip && privOk && fieldsValid_reg && !bufFull;
        storeDone = clockEn && (state_reg == bts_pkg::S_WRITE) && memAck;
        fetchDone = clockEn && (state_reg == bts_pkg::S_FETCH) && memAck && (fetchCnt_reg == bts_pkg::FETCH_LAST);
    end

    // bus message when select is clear or both skip bits are set
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busMsgValid_reg <= 1'b0;
            busMsgData_reg  <= bts_pkg::WORD_ZERO;
        end else if (clockEn) begin
            busMsgValid_reg <= sendBus;
            if (sendBus)
                busMsgData_reg <= recData;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // controller: fetch the management area, then write records

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            bts_pkg::S_IDLE: begin
                // fields come from the area pointer
                if (storeMode && !fieldsValid_reg)
                    state_next = bts_pkg::S_FETCH;
                else if (sendStore)
                    state_next = bts_pkg::S_WRITE;
            end
            bts_pkg::S_FETCH: begin
                if (fetchDone)
                    state_next = bts_pkg::S_IDLE;
            end
            bts_pkg::S_WRITE: begin
                if (storeDone)
                    state_next = bts_pkg::S_IDLE;
            end
            default: state_next = bts_pkg::S_IDLE;
        endcase
    end

    // state, memory request and record stall
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg    <= bts_pkg::S_IDLE;
            fetchCnt_reg <= 2'h0;
            memReq_reg   <= 1'b0;
            memWrite_reg <= 1'b0;
            memAddr_reg  <= bts_pkg::WORD_ZERO;
            memWdata_reg <= bts_pkg::WORD_ZERO;
            recReady_reg <= 1'b0;
        end else if (clockEn) begin
            state_reg    <= state_next;
            recReady_reg <= (state_next == bts_pkg::S_IDLE) && !(storeMode && !fieldsValid_reg);
            if (state_reg == bts_pkg::S_IDLE && state_next == bts_pkg::S_FETCH) begin
                fetchCnt_reg <= 2'h0;
                memReq_reg   <= 1'b1;
                memWrite_reg <= 1'b0;
                memAddr_reg  <= areaPtr_reg + bts_pkg::AREA_BASE_OFS;
            end else if (state_reg == bts_pkg::S_IDLE && state_next == bts_pkg::S_WRITE) begin
                // record written at the current index
                memReq_reg   <= 1'b1;
                memWrite_reg <= 1'b1;
                memAddr_reg  <= index_reg;
                memWdata_reg <= recData;
            end else if (state_reg == bts_pkg::S_FETCH && memAck && !fetchDone) begin
                fetchCnt_reg <= fetchCnt_reg + 2'h1;
                memAddr_reg  <= memAddr_reg + bts_pkg::RECORD_SIZE;
            end else if (memAck) begin
                memReq_reg   <= 1'b0;
                memWrite_reg <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // management fields

    always_comb begin
        index_next = index_reg + bts_pkg::RECORD_SIZE;
        // circular buffer when irq enable is clear
        // wrap back to base at the maximum
        if (!ctrl_reg[bts_pkg::IRQEN_BIT] && index_next >= absMax_reg)
            index_next = base_reg;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            base_reg        <= bts_pkg::WORD_ZERO;
            index_reg       <= bts_pkg::WORD_ZERO;
            absMax_reg      <= bts_pkg::WORD_ZERO;
            thresh_reg      <= bts_pkg::WORD_ZERO;
            fieldsValid_reg <= 1'b0;
        end else if (clockEn) begin
            if (state_reg == bts_pkg::S_FETCH && memAck) begin
                unique case (fetchCnt_reg)
                    2'h0:    base_reg   <= memRdata;
                    2'h1:    index_reg  <= memRdata;
                    2'h2:    absMax_reg <= memRdata;
                    default: thresh_reg <= memRdata;
                endcase
            end
            if (fetchDone)
                fieldsValid_reg <= 1'b1;
            else if (apbWr && paddr == bts_pkg::AREA_PTR_OFS)
                fieldsValid_reg <= 1'b0;
            // software index reset wins over a store
            if (wrIndex)
                index_reg <= pwdata;
            else if (storeDone)
                index_reg <= index_next;
            if (apbWr && paddr == bts_pkg::BUF_BASE_OFS)
                base_reg <= pwdata;
            if (apbWr && paddr == bts_pkg::ABS_MAX_OFS)
                absMax_reg <= pwdata;
            if (apbWr && paddr == bts_pkg::THRESH_OFS)
                thresh_reg <= pwdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // shared interrupt

    always_comb begin
        statusSet = '0;
        // near full only with irq enable
        statusSet[bts_pkg::ST_TRACE]  = storeDone && ctrl_reg[bts_pkg::IRQEN_BIT] && (index_next >= thresh_reg);
        statusSet[bts_pkg::ST_PREC]   = precIndex >= precThresh;
        statusSet[bts_pkg::ST_CNTOVF] = counterOverflow;
    end

    // sticky flags, set wins over a software clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            status_reg <= '0;
        else if (clockEn) begin
            if (apbWr && paddr == bts_pkg::STATUS_OFS)
                status_reg <= (status_reg & ~pwdata[bts_pkg::ST_W-1:0]) | statusSet;
            else
                status_reg <= status_reg | statusSet;
        end
    end

    // delivery sets the mask, software clears it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            perfIrq_reg <= 1'b0;
            lvtMask_reg <= 1'b0;
        end else if (clockEn) begin
            perfIrq_reg <= (|status_reg) && !lvtMask_reg;
            if ((|status_reg) && !lvtMask_reg)
                lvtMask_reg <= 1'b1;
            else if (apbWr && paddr == bts_pkg::LVT_OFS)
                lvtMask_reg <= pwdata[bts_pkg::MASK_BIT];
        end
    end

    // outputs straight from flops
    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign recReady    = recReady_reg;
    assign busMsgValid = busMsgValid_reg;
    assign busMsgData  = busMsgData_reg;
    assign memReq      = memReq_reg;
    assign memWrite    = memWrite_reg;
    assign memAddr     = memAddr_reg;
    assign memWdata    = memWdata_reg;
    assign perfIrq     = perfIrq_reg;

    //////////////////////////////////////////////////////////////////////////
    // checks

    msgOff_a: assert property (@(posedge clock) disable iff (!rstn)
        acceptRec && !msgOn |=> !busMsgValid && !memReq)
        else $error("message produced while messages off");
    busRoute_a: assert property (@(posedge clock) disable iff (!rstn)
        acceptRec && msgOn && !ctrl_reg[bts_pkg::SEL_BIT] |=> busMsgValid && busMsgData == $past(recData))
        else $error("bus message missing");
    storeRoute_a: assert property (@(posedge clock) disable iff (!rstn)
        sendStore && state_reg == bts_pkg::S_IDLE |=> memReq && memWrite && memAddr == $past(index_reg))
        else $error("record not written at index");
    oneDest_a: assert property (@(posedge clock) disable iff (!rstn)
        busMsgValid |-> !$rose(memWrite))
        else $error("message sent to both destinations");
    nearFull_a: assert property (@(posedge clock) disable iff (!rstn)
        storeDone && ctrl_reg[bts_pkg::IRQEN_BIT] && index_next >= thresh_reg |=> status_reg[bts_pkg::ST_TRACE])
        else $error("threshold not flagged");
    circWrap_a: assert property (@(posedge clock) disable iff (!rstn)
        storeDone && !wrIndex && !ctrl_reg[bts_pkg::IRQEN_BIT] && index_reg + bts_pkg::RECORD_SIZE >= absMax_reg
        |=> index_reg == $past(base_reg))
        else $error("circular index did not wrap");
    idxStep_a: assert property (@(posedge clock) disable iff (!rstn)
        storeDone && !wrIndex && index_reg + bts_pkg::RECORD_SIZE < absMax_reg
        |=> index_reg == $past(index_reg) + bts_pkg::RECORD_SIZE)
        else $error("index not advanced by one record");
    kernSkip_a: assert property (@(posedge clock) disable iff (!rstn)
        acceptRec && ctrl_reg[bts_pkg::SKIPK_BIT] && recPriv == bts_pkg::PRIV_KERNEL |=> !memWrite)
        else $error("kernel record stored");
    userSkip_a: assert property (@(posedge clock) disable iff (!rstn)
        acceptRec && ctrl_reg[bts_pkg::SKIPU_BIT] && recPriv != bts_pkg::PRIV_KERNEL |=> !memWrite)
        else $error("user record stored");
    bothSkip_a: assert property (@(posedge clock) disable iff (!rstn)
        acceptRec && storeMode && bothSkip |=> busMsgValid && !memWrite)
        else $error("both skip bits mishandled");
    irqMask_a: assert property (@(posedge clock) disable iff (!rstn)
        perfIrq && clockEn |-> lvtMask_reg ##1 !perfIrq)
        else $error("interrupt not masked after delivery");

    storeCov_c: cover property (@(posedge clock) disable iff (!rstn) storeDone);
    wrapCov_c: cover property (@(posedge clock) disable iff (!rstn)
        storeDone && !ctrl_reg[bts_pkg::IRQEN_BIT] && index_next == base_reg);
    irqCov_c: cover property (@(posedge clock) disable iff (!rstn) perfIrq);
    busCov_c: cover property (@(posedge clock) disable iff (!rstn) busMsgValid);
endmodule

/* verif/bts_mem_model.sv */
// memory model holding the management area and the trace buffer
// assumes one request at a time, held by the controller until acknowledged
module bts_mem_model (
    input  logic        clock,
    input  logic        rstn,
    input  logic [3:0]  lat,
    input  logic        memReq,
    input  logic        memWrite,
    input  logic [31:0] memAddr,
    input  logic [31:0] memWdata,
    output logic        memAck,
    output logic [31:0] memRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] words [64];
    logic [3:0]  waitCnt;
    ////////////////////////////////////////
    // fields served from area
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            memAck   <= 1'b0;
            waitCnt  <= 4'h0;
            memRdata <= 32'h0;
        end else if (memReq && !memAck && waitCnt >= lat) begin
            memAck   <= 1'b1;
            waitCnt  <= 4'h0;
            memRdata <= words[memAddr[7:2]];
            if (memWrite)
                words[memAddr[7:2]] <= memWdata;
        end else begin
            memAck   <= 1'b0;
            waitCnt  <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
            // read data does not hold once the answer is gone
            memRdata <= ~memRdata;
        end
    end
endmodule

/* verif/tb_top.sv */
// bench for the branch store controller: apb and record tasks, checks
// assumes the memory model answers the controller's memory port
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        recValid = 1'b0, counterOverflow = 1'b0, clockEn = 1'b1, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, recData = 32'h0, precIndex = 32'h0, precThresh = 32'h1;
    logic [1:0]  recPriv = 2'h0;
    logic [3:0]  lat = 4'h0;
    logic [31:0] prdata, memAddr, memWdata, memRdata, busMsgData, busLast, rd;
    logic        pready, pslverr, recReady, busMsgValid, memReq, memWrite, memAck, perfIrq;
    int          fail_count = 0, checked = 0, busCnt = 0, irqCnt = 0;
    always #4 clock = ~clock;
    bts_store_ctrl DUT (.clock, .rstn, .clockEn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .recValid, .recData, .recPriv, .recReady, .busMsgValid,
        .busMsgData, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata, .precIndex,
        .precThresh, .counterOverflow, .perfIrq);
    bts_mem_model mem (.clock, .rstn, .lat, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata);
    ////////////////////////////////////////
    // counts bus messages and interrupt pulses
    always @(posedge clock) begin
        if (busMsgValid === 1'b1) begin
            busCnt++;
            busLast = busMsgData;
        end
        if (perfIrq === 1'b1)
            irqCnt++;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    // offers one record and holds it until taken
    task automatic rec(input logic [31:0] d, input logic [1:0] p);
        @(posedge clock);
        recValid <= 1'b1;
        recData  <= d;
        recPriv  <= p;
        do @(posedge clock); while (recReady !== 1'b1);
        recValid <= 1'b0;
    endtask
    // waits for the memory port to go quiet, then for a late irq pulse
    task automatic settle();
        int n = 0;
        do begin
            @(posedge clock);
            n++;
        end while ((memReq !== 1'b0 || recReady !== 1'b1) && n < 60);
        // a port that never goes quiet counts as a mismatch
        if (n >= 60)
            fail_count++;
        repeat (3) @(posedge clock);
    endtask
    task automatic test_done();
        $display("counts: %0d checks, %0d mismatches", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        test_done();
    end
    ////////////////////////////////////////
    initial begin
        // area at 0x40: base 0x80, index 0x80, maximum 0x90, threshold 0x88
        // bit 2 clear
        mem.words[16] = 32'h80;
        mem.words[17] = 32'h80;
        mem.words[18] = 32'h90;
        mem.words[19] = 32'h88;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rdc("ctrl reset", bts_pkg::CTRL_OFS, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        // an overflow while the enable is low is not seen
        clockEn         <= 1'b0;
        counterOverflow <= 1'b1;
        @(posedge clock);
        counterOverflow <= 1'b0;
        @(posedge clock);
        clockEn         <= 1'b1;
        settle();
        chk("frozen", irqCnt, 32'h0);
        rec(32'hA1, 2'h0);
        settle();
        chk("msgs off", busCnt, 32'h0);
        apb(1'b1, bts_pkg::CTRL_OFS, 32'h1);
        rec(32'hB2, 2'h2);
        settle();
        chk("bus msg", busLast, 32'hB2);
        $display("test messages done");
        apb(1'b1, bts_pkg::AREA_PTR_OFS, 32'h40);
        apb(1'b1, bts_pkg::CTRL_OFS, 32'h3);
        for (int i = 0; i < 5; i++)
            rec(32'hC0 + i, 2'h1);
        settle();
        chk("wrapped", mem.words[32], 32'hC4);
        chk("third", mem.words[34], 32'hC2);
        rdc("index wrap", bts_pkg::INDEX_OFS, 32'h84);
        chk("no bus", busCnt, 32'h1);
        chk("no irq", irqCnt, 32'h0);
        $display("test circular done");
        apb(1'b1, bts_pkg::INDEX_OFS, 32'h80);
        apb(1'b1, bts_pkg::CTRL_OFS, 32'hB);
        rec(32'hD0, 2'h0);
        rec(32'hD1, 2'h3);
        settle();
        chk("skip kernel", mem.words[32], 32'hD1);
        apb(1'b1, bts_pkg::CTRL_OFS, 32'h13);
        rec(32'hD2, 2'h3);
        rec(32'hD3, 2'h0);
        settle();
        chk("skip user", mem.words[33], 32'hD3);
        apb(1'b1, bts_pkg::CTRL_OFS, 32'h1B);
        rec(32'hD4, 2'h0);
        settle();
        rdc("both skip", bts_pkg::INDEX_OFS, 32'h88);
        chk("both skip msg", busLast, 32'hD4);
        $display("test filter done");
        lat <= 4'h5;
        apb(1'b1, bts_pkg::INDEX_OFS, 32'h80);
        apb(1'b1, bts_pkg::CTRL_OFS, 32'h7);
        rec(32'hE0, 2'h1);
        rec(32'hE1, 2'h1);
        settle();
        chk("irq", irqCnt, 32'h1);
        rdc("status trace", bts_pkg::STATUS_OFS, 32'h1);
        rdc("mask set", bts_pkg::LVT_OFS, 32'h1);
        for (int i = 2; i < 5; i++)
            rec(32'hE0 + i, 2'h1);
        settle();
        rdc("full index", bts_pkg::INDEX_OFS, 32'h90);
        rdc("still on", bts_pkg::CTRL_OFS, 32'h7);
        chk("masked", irqCnt, 32'h1);
        apb(1'b1, bts_pkg::CTRL_OFS, 32'h0);
        apb(1'b1, bts_pkg::INDEX_OFS, 32'h80);
        apb(1'b1, bts_pkg::STATUS_OFS, 32'h7);
        apb(1'b1, bts_pkg::LVT_OFS, 32'h0);
        apb(1'b1, bts_pkg::CTRL_OFS, 32'h7);
        @(posedge clock);
        counterOverflow <= 1'b1;
        @(posedge clock);
        counterOverflow <= 1'b0;
        settle();
        chk("ovf irq", irqCnt, 32'h2);
        rdc("status ovf", bts_pkg::STATUS_OFS, 32'h4);
        apb(1'b1, bts_pkg::STATUS_OFS, 32'h4);
        precIndex <= 32'h5;
        precThresh <= 32'h5;
        apb(1'b1, bts_pkg::LVT_OFS, 32'h0);
        settle();
        chk("prec irq", irqCnt, 32'h3);
        rdc("status prec", bts_pkg::STATUS_OFS, 32'h2);
        $display("test interrupt done");
        test_done();
    end
endmodule
